// ==== common/nvc_pkg.sv ====
// nvc_pkg: opcodes, status layout, reset values and timing for the
// serial nvram command and status block.
// assumes a 100 MHz system clock sampling the serial pins.
`default_nettype none
package nvc_pkg;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;
  localparam logic [7:0] OP_SW_STORE = 8'h3c;
  localparam logic [7:0] OP_SW_RECALL = 8'h60;
  localparam logic [7:0] OP_AS_ON = 8'h59;
  localparam logic [7:0] OP_AS_OFF = 8'h19;

  localparam int ST_GUARD_EN = 7;
  localparam int ST_BLK_HI = 3;
  localparam int ST_BLK_LO = 2;
  localparam int ST_LATCH = 1;
  localparam int ST_BUSY = 0;
  localparam logic [7:0] ST_WR_MASK = 8'h8c;
  localparam logic [2:0] NV_RESET = 3'h0;
  localparam logic AUTO_SAVE_RESET = 1'b1;

  localparam int CLK_PERIOD_NS = 10;
  localparam int STORE_TIME_NS = 8000;
  localparam int RECALL_TIME_NS = 200;
  localparam int STORE_CYC = (STORE_TIME_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int RECALL_CYC = (RECALL_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;

  typedef struct packed {
    logic guard_en;
    logic blk_hi;
    logic blk_lo;
  } nvc_guard_t;

  typedef struct packed {
    logic sel;
    logic sck_rise;
    logic sck_fall;
    logic sdi;
  } nvc_link_t;
endpackage : nvc_pkg
`default_nettype wire

// ==== hw/nvc_cmd_status.sv ====
// nvc_cmd_status: opcode decoding, status register and write latch of
// a serial nonvolatile sram. pins sampled by mclk_in.
// assumes a spi master in mode 0 or 3 drives sel_n, sck and sdi.
//
// Function
// - opcodes 06 set latch, 04 clear latch, 05 read status, 01 write status
// - opcode 03 is array read, 02 is array write
// - 3c store, 60 recall, 59 auto save on, 19 auto save off
// - every command starts at select falling edge, msb first
// - active while selected; standby only after store or recall ends
// - status: guard enable 7, x 6..4, block hi 3, lo 2, latch 1, busy 0
// - busy bit read-only, one during store or recall
// - status write changes only bits 7, 3 and 2
// - bits 6..4 read zero after power-up, never written
// - write latch zero after power-up
// - guard bits, latch and spare bits reset to zero
// - status write is opcode plus eight data bits, needs latch set
// - guard bits become nonvolatile only after a store
// - write guard pin acts only when guard enable is one
// - write-class commands accepted only with latch set
// - without latch, write-class commands ignored until next select
// - set latch command sets latch bit
// - latch cleared after any completed write-class command
// - status read shifts status out on sdo
// - block guard bits select one of four protection levels
// - unknown opcode: ignore input until next select, sdo high-z
// - sample on rising sck, drive on falling, modes 0 and 3
// - 00 none, 01 6000-7fff, 10 4000-7fff, 11 0000-7fff protected
// - clear latch command acts at select rising edge
`default_nettype none
module nvc_cmd_status
  import nvc_pkg::*;
#(
  parameter int STORE_CYCLES = nvc_pkg::STORE_CYC,
  parameter int RECALL_CYCLES = nvc_pkg::RECALL_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic sel_n_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  input wire logic guard_pin_n_in,
  input wire logic [14:0] arr_addr_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic active_out,
  output logic busy_out,
  output logic arr_rd_out,
  output logic arr_wr_out,
  output logic arr_wr_ok_out,
  output logic auto_save_out,
  output logic [7:0] status_out,
  output logic [7:0] nv_status_out
);
  import nvc_pkg::*;

  initial begin
    if (STORE_CYCLES < 8 || STORE_CYCLES > 8192 || RECALL_CYCLES < 1
        || RECALL_CYCLES > 8192) begin
      $error("cycle counts outside 8..8192 store or 1..8192 recall");
    end
  end

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_OPC = 6'b000010,
    S_STWR = 6'b000100,
    S_STRD = 6'b001000,
    S_PASS = 6'b010000,
    S_IGN = 6'b100000
  } nvc_state_t;

  function automatic logic blk_hit(input logic [1:0] lvl,
                                   input logic [14:0] a);
    unique case (lvl)
      2'b00: blk_hit = 1'b0;
      2'b01: blk_hit = a >= 15'h6000;
      2'b10: blk_hit = a >= 15'h4000;
      2'b11: blk_hit = 1'b1;
    endcase
  endfunction

  logic [3:0] lvl, rise, fall;
  nvc_link_t lk;
  logic guard_pin_n;
  nvc_pin_sync #(.WIDTH(4)) u_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pin_in({sel_n_in, sck_in, sdi_in, guard_pin_n_in}),
    .init_in(4'h9),
    .level_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );
  assign lk.sel = ~lvl[3];
  assign lk.sck_rise = rise[2];
  assign lk.sck_fall = fall[2];
  assign lk.sdi = lvl[1];
  assign guard_pin_n = lvl[0];
  logic sel_fall, sel_rise;
  assign sel_fall = fall[3];
  assign sel_rise = rise[3];

  nvc_state_t st, next_st;
  logic [7:0] shreg, next_shreg;
  logic [3:0] cnt, next_cnt;
  logic latch, next_latch;
  logic armed, next_armed;
  nvc_guard_t guard, next_guard, nv_guard, next_nv_guard;
  logic auto_save, next_auto_save;
  logic [1:0] pend, next_pend;
  logic [12:0] busy_cnt, next_busy_cnt;
  logic busy, next_busy;
  logic [7:0] sdo_sh, next_sdo_sh;
  logic sdo, next_sdo, sdo_oe, next_sdo_oe;
  logic arr_rd, next_arr_rd, arr_wr, next_arr_wr;
  logic wr_ok, next_wr_ok;
  logic [7:0] status;
  logic stat_locked;

  // pend: 0 none, 2 store, 3 recall; 1 never used
  assign status = {guard.guard_en, 3'h0, guard.blk_hi, guard.blk_lo,
                   latch, busy};
  assign stat_locked = guard.guard_en & ~guard_pin_n;

  always_comb begin
    next_st = st;
    next_shreg = shreg;
    next_cnt = cnt;
    next_latch = latch;
    next_armed = armed;
    next_guard = guard;
    next_nv_guard = nv_guard;
    next_auto_save = auto_save;
    next_pend = pend;
    next_busy_cnt = busy_cnt;
    next_busy = busy;
    next_sdo_sh = sdo_sh;
    next_sdo = sdo;
    next_sdo_oe = sdo_oe;
    next_arr_rd = arr_rd;
    next_arr_wr = arr_wr;
    next_wr_ok = arr_wr & latch
                 & ~blk_hit({guard.blk_hi, guard.blk_lo}, arr_addr_in);
    if (busy) begin
      if (busy_cnt == 13'h0) begin
        next_busy = 1'b0;
      end else begin
        next_busy_cnt = busy_cnt - 13'h1;
      end
    end
    if (sel_fall && !busy) begin
      next_st = S_OPC;
      next_cnt = 4'h0;
      next_armed = 1'b0;
      next_pend = 2'h0;
    end else if (sel_rise || !lk.sel) begin
      next_st = S_IDLE;
      next_sdo_oe = 1'b0;
      next_arr_rd = 1'b0;
      next_arr_wr = 1'b0;
      if (sel_rise) begin
        if (armed) begin
          next_latch = 1'b0;
        end
        if (pend == 2'h2) begin
          next_nv_guard = guard;
          next_busy = 1'b1;
          next_busy_cnt = 13'(STORE_CYCLES - 1);
        end else if (pend == 2'h3) begin
          next_guard = nv_guard;
          next_busy = 1'b1;
          next_busy_cnt = 13'(RECALL_CYCLES - 1);
        end
        next_armed = 1'b0;
        next_pend = 2'h0;
      end
    end else begin
      unique case (st)
        S_IDLE, S_IGN, S_PASS: begin
        end
        S_OPC: begin
          if (lk.sck_rise) begin
            next_shreg = {shreg[6:0], lk.sdi};
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) begin
              next_cnt = 4'h0;
              next_st = S_IGN;
              unique case (next_shreg)
                OP_SET_LATCH: next_latch = 1'b1;
                OP_CLR_LATCH: next_armed = 1'b1;
                OP_STAT_RD: begin
                  next_st = S_STRD;
                  next_sdo_sh = status;
                end
                OP_STAT_WR: begin
                  if (latch) next_st = S_STWR;
                end
                OP_ARR_RD: begin
                  next_st = S_PASS;
                  next_arr_rd = 1'b1;
                end
                OP_ARR_WR: begin
                  if (latch) begin
                    next_st = S_PASS;
                    next_arr_wr = 1'b1;
                    next_armed = 1'b1;
                  end
                end
                OP_SW_STORE, OP_SW_RECALL: begin
                  if (latch) begin
                    next_armed = 1'b1;
                    next_pend = (next_shreg == OP_SW_STORE) ? 2'h2 : 2'h3;
                  end
                end
                OP_AS_ON, OP_AS_OFF: begin
                  if (latch) begin
                    next_auto_save = (next_shreg == OP_AS_ON);
                    next_armed = 1'b1;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
        S_STWR: begin
          if (lk.sck_rise) begin
            next_shreg = {shreg[6:0], lk.sdi};
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) begin
              next_st = S_IGN;
              next_armed = 1'b1;
              if (!stat_locked) begin
                next_guard.guard_en = next_shreg[ST_GUARD_EN];
                next_guard.blk_hi = next_shreg[ST_BLK_HI];
                next_guard.blk_lo = next_shreg[ST_BLK_LO];
              end
            end
          end
        end
        S_STRD: begin
          if (lk.sck_fall) begin
            next_sdo_oe = 1'b1;
            next_sdo = sdo_sh[7];
            next_sdo_sh = {sdo_sh[6:0], sdo_sh[7]};
          end
        end
        default: next_st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st <= S_IDLE;
      shreg <= 8'h00;
      cnt <= 4'h0;
      latch <= 1'b0;
      armed <= 1'b0;
      guard <= NV_RESET;
      nv_guard <= NV_RESET;
      auto_save <= AUTO_SAVE_RESET;
      pend <= 2'h0;
      busy_cnt <= 13'h0;
      busy <= 1'b0;
      sdo_sh <= 8'h00;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      arr_rd <= 1'b0;
      arr_wr <= 1'b0;
      wr_ok <= 1'b0;
      active_out <= 1'b0;
      status_out <= 8'h00;
      nv_status_out <= 8'h00;
    end else begin
      st <= next_st;
      shreg <= next_shreg;
      cnt <= next_cnt;
      latch <= next_latch;
      armed <= next_armed;
      guard <= next_guard;
      nv_guard <= next_nv_guard;
      auto_save <= next_auto_save;
      pend <= next_pend;
      busy_cnt <= next_busy_cnt;
      busy <= next_busy;
      sdo_sh <= next_sdo_sh;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      arr_rd <= next_arr_rd;
      arr_wr <= next_arr_wr;
      wr_ok <= next_wr_ok;
      active_out <= lk.sel | busy;
      status_out <= status;
      nv_status_out <= {nv_guard.guard_en, 3'h0, nv_guard.blk_hi,
                        nv_guard.blk_lo, 2'h0};
    end
  end

  assign sdo_out = sdo;
  assign sdo_oe_out = sdo_oe;
  assign busy_out = busy;
  assign arr_rd_out = arr_rd;
  assign arr_wr_out = arr_wr;
  assign arr_wr_ok_out = wr_ok;
  assign auto_save_out = auto_save;

  sequence s_store_go;
    sel_rise && pend == 2'h2;
  endsequence
  a_store_busy: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_store_go |=> busy [*8]) else $error("busy low during store");
  a_latch_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    sel_rise && armed |=> !latch) else $error("latch kept");
  a_latch_reset: assert property (@(posedge mclk_in)
    !rst_n_in |=> !latch && guard == 3'h0) else $error("bad reset");
  a_spare_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    status[6:4] == 3'h0) else $error("spare bits set");
  a_no_latch_wr: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !latch |=> !$rose(arr_wr)) else $error("write without latch");
  a_guard_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    stat_locked && st == S_STWR |=> $stable(guard) || $past(sel_rise))
    else $error("guarded status changed");
  a_sdo_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    st == S_IGN |-> !sdo_oe) else $error("sdo driven on ignore");
  a_desel_off: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    sel_rise |=> !sdo_oe ##1 !sdo_oe) else $error("sdo after deselect");
  a_active_sel: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    lk.sel |=> active_out) else $error("not active");
endmodule : nvc_cmd_status
`default_nettype wire

// ==== hw/nvc_pin_sync.sv ====
// nvc_pin_sync: three-flop synchroniser with agreement filter for the
// serial pins, plus edge detection on the filtered level.
// assumes pins are asynchronous to mclk_in.
`default_nettype none
module nvc_pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] init_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] s1, s2, s3, lvl;
  logic [WIDTH-1:0] next_lvl;

  always_comb begin
    next_lvl = lvl;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) begin
        next_lvl[i] = s3[i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      // start at the idle level so reset makes no false edge
      s1 <= init_in;
      s2 <= init_in;
      s3 <= init_in;
      lvl <= init_in;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
    end
  end

  assign level_out = lvl;
  assign rise_out = next_lvl & ~lvl;
  assign fall_out = ~next_lvl & lvl;
endmodule : nvc_pin_sync
`default_nettype wire

// ==== tb/nvc_spi_master.sv ====
// nvc_spi_master: behavioural spi master for the command/status block.
// assumes the bench calls frame and release_sel hierarchically.
`default_nettype none
module nvc_spi_master (
  output logic sel_n_out,
  output logic sck_out,
  output logic sdi_out,
  input wire logic sdo_in,
  input wire logic sdo_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 40ns;
  logic oe_seen;
  logic [31:0] rx;
  initial begin
    sel_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
    oe_seen = 1'b0;
    rx = '0;
  end
  always @(posedge sdo_oe_in) oe_seen = 1'b1;
  // n bits of d, msb first; keep leaves the device selected
  task automatic frame(input logic [31:0] d, input int n, input bit m3,
                       input bit keep);
    oe_seen = 1'b0;
    rx = '0;
    #3;
    sck_out = m3;
    #(HALF);
    sel_n_out = 1'b0;
    #(HALF);
    for (int i = n - 1; i >= 0; i--) begin
      sck_out = 1'b0;
      sdi_out = d[i];
      #(HALF);
      sck_out = 1'b1;
      #(HALF - 1ns);
      rx = {rx[30:0], sdo_in};
      #1;
    end
    if (!m3) sck_out = 1'b0;
    if (!keep) release_sel();
  endtask
  task automatic release_sel();
    #(HALF);
    sel_n_out = 1'b1;
    // released line must not keep its last value
    sdi_out = ~sdi_out;
    #(5 * HALF);
  endtask
endmodule // nvc_spi_master
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: table-driven check of opcode decode and status register.
// assumes nvc_pkg and the spi master model are compiled first.
`default_nettype none
module testbench;
  import nvc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] dt;
    logic gp;
    logic [7:0] st;
    logic as;
  } nvc_row_t;
  logic mclk, rst_n, sel_n, sck, sdi, guard_n, sdo, sdo_oe, active, busy;
  logic arr_rd, arr_wr, wr_ok, auto_save;
  logic [14:0] addr;
  logic [7:0] status, nv_status, s;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  // st of ff: status not compared after that row
  nvc_row_t rows [24] = '{
    '{8'h04,8'h00,1'h1,8'h00,1'h1}, '{8'h06,8'h00,1'h1,8'h02,1'h1},
    '{8'h04,8'h00,1'h1,8'h00,1'h1}, '{8'h06,8'h00,1'h1,8'h02,1'h1},
    '{8'h01,8'hfe,1'h1,8'h8c,1'h1}, '{8'h01,8'h00,1'h1,8'h8c,1'h1},
    '{8'h1e,8'h00,1'h1,8'h8c,1'h1}, '{8'h06,8'h00,1'h1,8'h8e,1'h1},
    '{8'hff,8'h00,1'h1,8'h8e,1'h1}, '{8'h01,8'h04,1'h1,8'h04,1'h1},
    '{8'h06,8'h00,1'h1,8'h06,1'h1}, '{8'h19,8'h00,1'h1,8'h04,1'h0},
    '{8'h59,8'h00,1'h1,8'h04,1'h0}, '{8'h06,8'h00,1'h1,8'h06,1'h0},
    '{8'h59,8'h00,1'h1,8'h04,1'h1}, '{8'h06,8'h00,1'h1,8'h06,1'h1},
    '{8'h01,8'h84,1'h1,8'h84,1'h1}, '{8'h06,8'h00,1'h0,8'h86,1'h1},
    '{8'h01,8'h00,1'h0,8'h84,1'h1}, '{8'h04,8'h00,1'h0,8'h84,1'h1},
    '{8'h06,8'h00,1'h1,8'h86,1'h1}, '{8'h01,8'h08,1'h1,8'h08,1'h1},
    '{8'h06,8'h00,1'h0,8'h0a,1'h1}, '{8'h01,8'h00,1'h0,8'h00,1'h1}};
  logic [14:0] bounds [6] = '{15'h0000, 15'h3fff, 15'h4000, 15'h5fff,
                              15'h6000, 15'h7fff};
  nvc_cmd_status #(.STORE_CYCLES(60), .RECALL_CYCLES(50)) i_nvc_cmd_status (
    .mclk_in(mclk), .rst_n_in(rst_n), .sel_n_in(sel_n), .sck_in(sck),
    .sdi_in(sdi), .guard_pin_n_in(guard_n), .arr_addr_in(addr),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .active_out(active),
    .busy_out(busy), .arr_rd_out(arr_rd), .arr_wr_out(arr_wr),
    .arr_wr_ok_out(wr_ok), .auto_save_out(auto_save),
    .status_out(status), .nv_status_out(nv_status));
  nvc_spi_master i_nvc_spi_master (.sel_n_out(sel_n), .sck_out(sck),
    .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(sdo_oe));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] dt,
                     input bit m3);
    @(posedge mclk);
    if (op == OP_STAT_WR) i_nvc_spi_master.frame({16'h0, op, dt}, 16, m3, 0);
    else i_nvc_spi_master.frame({24'h0, op}, 8, m3, 0);
  endtask
  task automatic rd_status(output logic [7:0] v);
    cmd(OP_STAT_RD, 8'h00, 0);
    cmd(OP_STAT_RD, 8'h00, 0);
    i_nvc_spi_master.frame({16'h0, OP_STAT_RD, 8'h00}, 16, 0, 0);
    v = i_nvc_spi_master.rx[7:0];
    chk1(i_nvc_spi_master.oe_seen, 1'b1);
  endtask
  task automatic wait_busy();
    int k;
    k = 0;
    while (busy !== 1'b1 && k < 200) begin
      @(posedge mclk);
      k++;
    end
    chk1(busy, 1'b1);
    chk1(status[0], 1'b1);
    chk1(active, 1'b1);
    k = 0;
    while (busy !== 1'b0 && k < 200) begin
      @(posedge mclk);
      k++;
    end
    repeat (2) @(posedge mclk);
    chk1(active, 1'b0);
  endtask
  function automatic logic guarded(input int lv, input logic [14:0] a);
    return (lv == 3) || (lv == 2 && a >= 15'h4000) ||
           (lv == 1 && a >= 15'h6000);
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    guard_n = 1'b1;
    addr = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rd_status(s);
    chk8(s, 8'h00);
    chk1(auto_save, 1'b1);
    for (int i = 0; i < 24; i++) begin
      @(posedge mclk);
      guard_n <= rows[i].gp;
      cmd(rows[i].op, rows[i].dt, i[0]);
      chk1(i_nvc_spi_master.oe_seen, 1'b0);
      if (rows[i].st !== 8'hff) begin
        rd_status(s);
        chk8(s, rows[i].st);
        chk8(status, rows[i].st);
      end
      chk1(auto_save, rows[i].as);
    end
    $display("table rows done");
    cmd(OP_SET_LATCH, 8'h00, 0);
    cmd(OP_STAT_WR, 8'h04, 0);
    cmd(OP_SET_LATCH, 8'h00, 1);
    cmd(OP_SW_STORE, 8'h00, 1);
    wait_busy();
    chk8(nv_status, 8'h04);
    cmd(OP_SET_LATCH, 8'h00, 0);
    cmd(OP_STAT_WR, 8'h08, 0);
    cmd(OP_SET_LATCH, 8'h00, 0);
    cmd(OP_SW_RECALL, 8'h00, 0);
    wait_busy();
    rd_status(s);
    chk8(s, 8'h04);
    $display("store and recall done");
    for (int lv = 0; lv < 4; lv++) begin
      cmd(OP_SET_LATCH, 8'h00, 0);
      cmd(OP_STAT_WR, {4'h0, lv[1:0], 2'h0}, 0);
      cmd(OP_SET_LATCH, 8'h00, 1);
      i_nvc_spi_master.frame({8'h0, OP_ARR_WR, 16'h0}, 24, 0, 1);
      chk1(arr_wr, 1'b1);
      for (int j = 0; j < 6; j++) begin
        @(posedge mclk);
        addr <= bounds[j];
        repeat (3) @(posedge mclk);
        chk1(wr_ok, !guarded(lv, bounds[j]));
      end
      i_nvc_spi_master.release_sel();
      rd_status(s);
      chk8(s, {4'h0, lv[1:0], 2'h0});
    end
    i_nvc_spi_master.frame({8'h0, OP_ARR_RD, 16'h0}, 24, 1, 1);
    chk1(arr_rd, 1'b1);
    chk1(active, 1'b1);
    i_nvc_spi_master.release_sel();
    $display("array guard done");
    cmd(OP_SET_LATCH, 8'h00, 0);
    cmd(OP_AS_OFF, 8'h00, 0);
    chk1(auto_save, 1'b0);
    cmd(OP_SET_LATCH, 8'h00, 0);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rd_status(s);
    chk8(s, 8'h00);
    chk1(auto_save, 1'b1);
    $display("reset done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
